// ==== iorsd_decoder.v ====
`timescale 1ns/1ps
`include "iorsd_consts.vh"

module iorsd_decoder (
	// clock and reset
	input wire sys_clk_in,
	input wire reset_in,
	// core request
	input wire req_valid_in,
	input wire [2:0] req_kind_in,
	input wire [7:0] req_addr_in,
	input wire [2:0] req_bit_in,
	input wire [7:0] req_wdata_in,
	// core answer
	output reg ack_out,
	output reg [7:0] rdata_out,
	output reg skip_out,
	output reg refused_out,
	// port pin levels
	input wire [7:0] pin_b_in,
	input wire [7:0] pin_c_in,
	input wire [7:0] pin_d_in,
	// port control
	output reg [7:0] port_b_dir_out,
	output reg [7:0] port_b_drive_out,
	output reg [7:0] port_c_dir_out,
	output reg [7:0] port_c_drive_out,
	output reg [7:0] port_d_dir_out,
	output reg [7:0] port_d_drive_out,
	// peripheral events and status
	input wire [47:0] flag_set_in,
	input wire cmp_level_in,
	input wire [1:0] spi_status_in,
	input wire [3:0] reset_cause_in,
	output reg [47:0] flags_out,
	output reg [3:0] reset_cause_out,
	// peripheral write strobe
	output reg per_wr_out,
	output reg [5:0] per_addr_out,
	output reg [7:0] per_wdata_out
);

	localparam NUM_FLAG_REGS = 6;

	reg [7:0] mem_q [0:63];
	reg [7:0] rd_raw;
	reg [5:0] io_addr;
	reg is_data;
	reg is_bitop;
	reg is_write;
	reg is_read;
	reg refuse;
	reg in_io;
	reg [5:0] ds_io;
	reg [7:0] ds_full;
	integer k;

	wire [7:0] new_val;
	wire [7:0] clr_mask;
	wire bit_val;
	wire acc_ok;
	wire wr_ok;
	wire [47:0] flags_d;

	// bits that are stored for plain read/write registers
	function [7:0] rw_mask;
		input [5:0] a;
		begin
			case (a)
				`IORSD_OFS_PB_DIR, `IORSD_OFS_PB_DRIVE,
				`IORSD_OFS_PD_DIR, `IORSD_OFS_PD_DRIVE,
				`IORSD_OFS_SCRATCH0, `IORSD_OFS_NVM_DATA,
				`IORSD_OFS_NVM_ADR_LO, `IORSD_OFS_NVM_ADR_HI,
				`IORSD_OFS_T0_COUNT, `IORSD_OFS_T0_CMP_A,
				`IORSD_OFS_T0_CMP_B, `IORSD_OFS_SCRATCH1,
				`IORSD_OFS_SCRATCH2, `IORSD_OFS_SPI_CTL,
				`IORSD_OFS_SPI_DATA: rw_mask = 8'hFF;
				`IORSD_OFS_PC_DIR, `IORSD_OFS_PC_DRIVE: rw_mask = `IORSD_MSK_PC;
				`IORSD_OFS_XIRQ_MASK: rw_mask = `IORSD_MSK_XIRQ;
				`IORSD_OFS_GEN_TMR: rw_mask = `IORSD_MSK_GEN_TMR;
				`IORSD_OFS_T0_CTL_A: rw_mask = `IORSD_MSK_T0_CTL_A;
				`IORSD_OFS_T0_CTL_B: rw_mask = `IORSD_MSK_T0_CTL_B;
				`IORSD_OFS_SPI_STAT: rw_mask = `IORSD_MSK_SPI_STAT;
				`IORSD_OFS_CMP_CS: rw_mask = `IORSD_MSK_CMP_RW;
				`IORSD_OFS_SLEEP_CTL: rw_mask = `IORSD_MSK_SLEEP;
				default: rw_mask = 8'h00;
			endcase
		end
	endfunction

	// offset of each write-one-to-clear flag register
	function [5:0] flag_addr;
		input integer i;
		begin
			case (i)
				0: flag_addr = `IORSD_OFS_T0_FLAGS;
				1: flag_addr = `IORSD_OFS_T1_FLAGS;
				2: flag_addr = `IORSD_OFS_T2_FLAGS;
				3: flag_addr = `IORSD_OFS_PCHG_FLAGS;
				4: flag_addr = `IORSD_OFS_XIRQ_FLAGS;
				default: flag_addr = `IORSD_OFS_CMP_CS;
			endcase
		end
	endfunction

	function [7:0] flag_mask;
		input integer i;
		begin
			case (i)
				0: flag_mask = `IORSD_MSK_T0_FLAGS;
				1: flag_mask = `IORSD_MSK_T1_FLAGS;
				2: flag_mask = `IORSD_MSK_T2_FLAGS;
				3: flag_mask = `IORSD_MSK_PCHG_FLAGS;
				4: flag_mask = `IORSD_MSK_XIRQ;
				default: flag_mask = `IORSD_MSK_CMP_FLAG;
			endcase
		end
	endfunction

	// any documented register, stored or not
	function mapped;
		input [5:0] a;
		begin
			case (a)
				`IORSD_OFS_PB_LEVEL, `IORSD_OFS_PC_LEVEL, `IORSD_OFS_PD_LEVEL,
				`IORSD_OFS_T0_FLAGS, `IORSD_OFS_T1_FLAGS, `IORSD_OFS_T2_FLAGS,
				`IORSD_OFS_PCHG_FLAGS, `IORSD_OFS_XIRQ_FLAGS,
				`IORSD_OFS_RST_CAUSE: mapped = 1'b1;
				default: mapped = (rw_mask(a) != 8'h00);
			endcase
		end
	endfunction

	// address resolution and legality
	always @* begin
		ds_full = req_addr_in - `IORSD_DS_OFFSET;
		ds_io = ds_full[5:0];
		is_data = (req_kind_in == `IORSD_KIND_LOAD) ||
			(req_kind_in == `IORSD_KIND_STORE);
		is_bitop = (req_kind_in == `IORSD_KIND_SET_BIT) ||
			(req_kind_in == `IORSD_KIND_CLR_BIT) ||
			(req_kind_in == `IORSD_KIND_SKIP_SET) ||
			(req_kind_in == `IORSD_KIND_SKIP_CLR);
		is_write = (req_kind_in == `IORSD_KIND_OUT) ||
			(req_kind_in == `IORSD_KIND_STORE) ||
			(req_kind_in == `IORSD_KIND_SET_BIT) ||
			(req_kind_in == `IORSD_KIND_CLR_BIT);
		is_read = ~is_write;
		if (is_data) begin
			io_addr = ds_io;
			in_io = (req_addr_in >= `IORSD_DS_OFFSET) &&
				(req_addr_in <= `IORSD_DS_IO_TOP);
			// below the window lies the core's own register file
			refuse = (req_addr_in < `IORSD_DS_OFFSET);
		end else begin
			io_addr = req_addr_in[5:0];
			in_io = 1'b1;
			// I/O operations cannot reach beyond six address bits
			refuse = (req_addr_in[7:6] != 2'h0);
		end
		if (is_bitop && (io_addr > `IORSD_BIT_TOP)) begin
			refuse = 1'b1;
		end
	end

	// read value of the addressed register
	always @* begin
		case (io_addr)
			`IORSD_OFS_PB_LEVEL: rd_raw = pin_b_in;
			`IORSD_OFS_PC_LEVEL: rd_raw = pin_c_in & `IORSD_MSK_PC;
			`IORSD_OFS_PD_LEVEL: rd_raw = pin_d_in;
			`IORSD_OFS_T0_FLAGS: rd_raw = flags_out[7:0];
			`IORSD_OFS_T1_FLAGS: rd_raw = flags_out[15:8];
			`IORSD_OFS_T2_FLAGS: rd_raw = flags_out[23:16];
			`IORSD_OFS_PCHG_FLAGS: rd_raw = flags_out[31:24];
			`IORSD_OFS_XIRQ_FLAGS: rd_raw = flags_out[39:32];
			`IORSD_OFS_RST_CAUSE: rd_raw = {4'h0, reset_cause_out};
			`IORSD_OFS_SPI_STAT: rd_raw = (mem_q[io_addr] & `IORSD_MSK_SPI_STAT) |
				{spi_status_in, 6'h00};
			`IORSD_OFS_CMP_CS: rd_raw = (mem_q[io_addr] & `IORSD_MSK_CMP_RW) |
				flags_out[47:40] | {2'h0, cmp_level_in, 5'h00};
			// reserved locations and bits fall out as zero through the mask
			default: rd_raw = mem_q[io_addr] & rw_mask(io_addr);
		endcase
	end

	assign acc_ok = req_valid_in && !refuse && in_io;
	// reserved addresses take no write at all
	assign wr_ok = acc_ok && is_write && mapped(io_addr);

	iorsd_bit_op u_bit_op (
		.old_in(rd_raw),
		.wdata_in(req_wdata_in),
		.bit_in(req_bit_in),
		.set_in(req_kind_in == `IORSD_KIND_SET_BIT),
		.clr_in(req_kind_in == `IORSD_KIND_CLR_BIT),
		.new_out(new_val),
		.clr_mask_out(clr_mask),
		.bit_out(bit_val)
	);

	// sticky flags; a set arriving with the clear wins
	genvar g;
	generate
		for (g = 0; g < NUM_FLAG_REGS; g = g + 1) begin : g_flag
			wire hit;
			assign hit = wr_ok && (io_addr == flag_addr(g));
			assign flags_d[g*8 +: 8] = ((flags_out[g*8 +: 8] &
				~(hit ? clr_mask : 8'h00)) | flag_set_in[g*8 +: 8]) &
				flag_mask(g);
		end
	endgenerate

	// answer to the core, one cycle after the request
	always @(posedge sys_clk_in) begin
		if (reset_in) begin
			ack_out <= 1'b0;
			rdata_out <= 8'h00;
			skip_out <= 1'b0;
			refused_out <= 1'b0;
		end else begin
			ack_out <= req_valid_in;
			refused_out <= req_valid_in && refuse;
			rdata_out <= (acc_ok && is_read) ? rd_raw : 8'h00;
			skip_out <= acc_ok && (((req_kind_in == `IORSD_KIND_SKIP_SET) && bit_val) ||
				((req_kind_in == `IORSD_KIND_SKIP_CLR) && !bit_val));
		end
	end

	// stored register bits
	always @(posedge sys_clk_in) begin
		if (reset_in) begin
			for (k = 0; k < 64; k = k + 1) begin
				mem_q[k] <= `IORSD_RST_VAL;
			end
		end else if (wr_ok) begin
			mem_q[io_addr] <= new_val & rw_mask(io_addr);
		end
	end

	// port control mirrors, driven straight from flops
	always @(posedge sys_clk_in) begin
		if (reset_in) begin
			port_b_dir_out <= `IORSD_RST_VAL;
			port_b_drive_out <= `IORSD_RST_VAL;
			port_c_dir_out <= `IORSD_RST_VAL;
			port_c_drive_out <= `IORSD_RST_VAL;
			port_d_dir_out <= `IORSD_RST_VAL;
			port_d_drive_out <= `IORSD_RST_VAL;
		end else if (wr_ok) begin
			case (io_addr)
				`IORSD_OFS_PB_DIR: port_b_dir_out <= new_val;
				`IORSD_OFS_PB_DRIVE: port_b_drive_out <= new_val;
				`IORSD_OFS_PC_DIR: port_c_dir_out <= new_val & `IORSD_MSK_PC;
				`IORSD_OFS_PC_DRIVE: port_c_drive_out <= new_val & `IORSD_MSK_PC;
				`IORSD_OFS_PD_DIR: port_d_dir_out <= new_val;
				`IORSD_OFS_PD_DRIVE: port_d_drive_out <= new_val;
				default: port_b_dir_out <= port_b_dir_out;
			endcase
		end
	end

	// flags and reset cause bits
	always @(posedge sys_clk_in) begin
		if (reset_in) begin
			flags_out <= 48'h000000000000;
			reset_cause_out <= 4'h0;
		end else begin
			flags_out <= flags_d;
			// cause bits clear by writing zero; a new cause wins
			if (wr_ok && (io_addr == `IORSD_OFS_RST_CAUSE)) begin
				reset_cause_out <= (reset_cause_out & new_val[3:0]) | reset_cause_in;
			end else begin
				reset_cause_out <= reset_cause_out | reset_cause_in;
			end
		end
	end

	// write strobe to peripherals; timer strobe bits pass here although they read zero
	always @(posedge sys_clk_in) begin
		if (reset_in) begin
			per_wr_out <= 1'b0;
			per_addr_out <= 6'h00;
			per_wdata_out <= 8'h00;
		end else begin
			per_wr_out <= wr_ok;
			if (wr_ok) begin
				per_addr_out <= io_addr;
				per_wdata_out <= new_val;
			end
		end
	end

endmodule // iorsd_decoder

// ==== iorsd_consts.vh ====
`ifndef IORSD_CONSTS_VH
`define IORSD_CONSTS_VH

// request kinds from the core
`define IORSD_KIND_IN        3'h0
`define IORSD_KIND_OUT       3'h1
`define IORSD_KIND_SET_BIT   3'h2
`define IORSD_KIND_CLR_BIT   3'h3
`define IORSD_KIND_SKIP_SET  3'h4
`define IORSD_KIND_SKIP_CLR  3'h5
`define IORSD_KIND_LOAD      3'h6
`define IORSD_KIND_STORE     3'h7

// address map limits
`define IORSD_BIT_TOP        6'h1F
`define IORSD_DS_OFFSET      8'h20
`define IORSD_DS_IO_TOP      8'h5F
`define IORSD_EXT_BASE       8'h60

// register offsets in I/O space
`define IORSD_OFS_PB_LEVEL   6'h03
`define IORSD_OFS_PB_DIR     6'h04
`define IORSD_OFS_PB_DRIVE   6'h05
`define IORSD_OFS_PC_LEVEL   6'h06
`define IORSD_OFS_PC_DIR     6'h07
`define IORSD_OFS_PC_DRIVE   6'h08
`define IORSD_OFS_PD_LEVEL   6'h09
`define IORSD_OFS_PD_DIR     6'h0A
`define IORSD_OFS_PD_DRIVE   6'h0B
`define IORSD_OFS_T0_FLAGS   6'h15
`define IORSD_OFS_T1_FLAGS   6'h16
`define IORSD_OFS_T2_FLAGS   6'h17
`define IORSD_OFS_PCHG_FLAGS 6'h1B
`define IORSD_OFS_XIRQ_FLAGS 6'h1C
`define IORSD_OFS_XIRQ_MASK  6'h1D
`define IORSD_OFS_SCRATCH0   6'h1E
`define IORSD_OFS_NVM_DATA   6'h20
`define IORSD_OFS_NVM_ADR_LO 6'h21
`define IORSD_OFS_NVM_ADR_HI 6'h22
`define IORSD_OFS_GEN_TMR    6'h23
`define IORSD_OFS_T0_CTL_A   6'h24
`define IORSD_OFS_T0_CTL_B   6'h25
`define IORSD_OFS_T0_COUNT   6'h26
`define IORSD_OFS_T0_CMP_A   6'h27
`define IORSD_OFS_T0_CMP_B   6'h28
`define IORSD_OFS_SCRATCH1   6'h2A
`define IORSD_OFS_SCRATCH2   6'h2B
`define IORSD_OFS_SPI_CTL    6'h2C
`define IORSD_OFS_SPI_STAT   6'h2D
`define IORSD_OFS_SPI_DATA   6'h2E
`define IORSD_OFS_CMP_CS     6'h30
`define IORSD_OFS_SLEEP_CTL  6'h33
`define IORSD_OFS_RST_CAUSE  6'h34

// implemented bit masks
`define IORSD_MSK_PC         8'h7F
`define IORSD_MSK_T0_FLAGS   8'h07
`define IORSD_MSK_T1_FLAGS   8'h27
`define IORSD_MSK_T2_FLAGS   8'h07
`define IORSD_MSK_PCHG_FLAGS 8'h07
`define IORSD_MSK_XIRQ       8'h03
`define IORSD_MSK_GEN_TMR    8'h83
`define IORSD_MSK_T0_CTL_A   8'hF3
`define IORSD_MSK_T0_CTL_B   8'h0F
`define IORSD_MSK_SPI_STAT   8'h01
`define IORSD_MSK_CMP_RW     8'hCF
`define IORSD_MSK_CMP_FLAG   8'h10
`define IORSD_MSK_SLEEP      8'h0F
`define IORSD_MSK_RST_CAUSE  8'h0F

// field positions
`define IORSD_POS_CMP_LEVEL  5
`define IORSD_POS_SPI_STAT   6

// reset value of every stored bit
`define IORSD_RST_VAL        8'h00

`endif

// ==== iorsd_bit_op.v ====
`timescale 1ns/1ps

module iorsd_bit_op (
	// current register value and request
	input wire [7:0] old_in,
	input wire [7:0] wdata_in,
	input wire [2:0] bit_in,
	input wire set_in,
	input wire clr_in,
	// results
	output wire [7:0] new_out,
	output wire [7:0] clr_mask_out,
	output wire bit_out
);

	wire [7:0] one_hot;

	assign one_hot = 8'h01 << bit_in;
	// for bit set/clear only the addressed bit changes, all others keep the old value; other requests pass wdata_in
	assign new_out = set_in ? (old_in | one_hot) :
		clr_in ? (old_in & ~one_hot) : wdata_in;
	// flags see a one only where a one is really written
	assign clr_mask_out = set_in ? one_hot : clr_in ? 8'h00 : wdata_in;
	assign bit_out = old_in[bit_in];

endmodule // iorsd_bit_op

// ==== iorsd_sva.sv ====
`timescale 1ns/1ps

module iorsd_sva (
	// clock and reset
	input wire sys_clk_in,
	input wire reset_in,
	// core request and events
	input wire req_valid_in,
	input wire [2:0] req_kind_in,
	input wire [7:0] req_addr_in,
	input wire [2:0] req_bit_in,
	input wire [7:0] req_wdata_in,
	input wire [47:0] flag_set_in,
	// answers and effects
	input wire ack_out,
	input wire [7:0] rdata_out,
	input wire skip_out,
	input wire refused_out,
	input wire [7:0] port_b_drive_out,
	input wire [47:0] flags_out,
	input wire per_wr_out,
	input wire [5:0] per_addr_out,
	input wire [7:0] per_wdata_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	wire v = req_valid_in;
	wire [2:0] k = req_kind_in;
	wire [7:0] a = req_addr_in;
	// flag checks skip cycles with event pulses, set wins there
	wire quiet = flag_set_in[7:0] == 8'h00;

	property p_ack; v |=> ack_out; endproperty
	a_ack: assert property (p_ack) else $error("request without answer");
	property p_idle; !v |=> !ack_out && !skip_out && !refused_out; endproperty
	a_idle: assert property (p_idle) else $error("answer without request");
	property p_bit_hi; v && k >= 3'h2 && k <= 3'h5 && a > 8'h1F |=> refused_out && !per_wr_out;
	endproperty
	a_bit_hi: assert property (p_bit_hi) else $error("bit op above low range");
	property p_io6; v && k <= 3'h1 && a[7:6] != 2'b00 |=> refused_out; endproperty
	a_io6: assert property (p_io6) else $error("in/out beyond six bits");
	property p_ds_lo; v && k >= 3'h6 && a < 8'h20 |=> refused_out && rdata_out == 8'h00;
	endproperty
	a_ds_lo: assert property (p_ds_lo) else $error("data access below offset");
	property p_ext; v && k == 3'h7 && a >= 8'h60 |=> !refused_out && !per_wr_out; endproperty
	a_ext: assert property (p_ext) else $error("extended store mishandled");
	property p_map;
		v && (k == 3'h1 && a == 8'h05 || k == 3'h7 && a == 8'h25) |=> per_wr_out &&
			per_addr_out == 6'h05 && port_b_drive_out == $past(req_wdata_in);
	endproperty
	a_map: assert property (p_map) else $error("port write misplaced");
	property p_skip; skip_out |-> $past(v) && ($past(k) == 3'h4 || $past(k) == 3'h5);
	endproperty
	a_skip: assert property (p_skip) else $error("skip without test");
	property p_w1c; v && k == 3'h1 && a == 8'h15 && quiet |=>
		flags_out[7:0] == ($past(flags_out[7:0]) & ~$past(req_wdata_in)); endproperty
	a_w1c: assert property (p_w1c) else $error("flag write wrong");
	property p_sbit; v && k == 3'h2 && a == 8'h15 && quiet |=>
		flags_out[7:0] == ($past(flags_out[7:0]) & ~(8'h01 << $past(req_bit_in))); endproperty
	a_sbit: assert property (p_sbit) else $error("bit set hit other flags");
	property p_rsv; v && k == 3'h1 && a == 8'h01 |=> !per_wr_out && rdata_out == 8'h00;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved write leaked");

	c_skip: cover property (skip_out);
	c_ref: cover property (refused_out);
	c_sbit: cover property (v && k == 3'h2 && a == 8'h15);
endmodule // iorsd_sva

bind iorsd_decoder iorsd_sva u_sva (.sys_clk_in, .reset_in, .req_valid_in, .req_kind_in,
	.req_addr_in, .req_bit_in, .req_wdata_in, .flag_set_in, .ack_out, .rdata_out,
	.skip_out, .refused_out, .port_b_drive_out, .flags_out, .per_wr_out, .per_addr_out,
	.per_wdata_out);

// ==== iorsd_core_model.sv ====
`timescale 1ns/1ps

module iorsd_core_model (
	// clock
	input wire sys_clk_in,
	// request to decoder
	output reg req_valid_out,
	output reg [2:0] req_kind_out,
	output reg [7:0] req_addr_out,
	output reg [2:0] req_bit_out,
	output reg [7:0] req_wdata_out,
	// answer from decoder
	input wire ack_in,
	input wire [7:0] rdata_in,
	input wire skip_in,
	input wire refused_in
);
	initial begin
		req_valid_out = 1'b0;
		req_kind_out = 3'h0;
		req_addr_out = 8'h00;
		req_bit_out = 3'h0;
		req_wdata_out = 8'h00;
	end

	// callers set reserved bits and hit reserved places only on purpose
	task acc(input [2:0] k, input [7:0] a, input [2:0] b, input [7:0] d,
		output ak, output [7:0] rd, output sk, output rf);
		begin
			@(posedge sys_clk_in);
			#1;
			req_valid_out = 1'b1;
			req_kind_out = k;
			req_addr_out = a;
			req_bit_out = b;
			req_wdata_out = d;
			@(posedge sys_clk_in);
			#1;
			req_valid_out = 1'b0;
			// released lines flip so a stale value cannot pass
			req_kind_out = ~k;
			req_addr_out = ~a;
			req_bit_out = ~b;
			req_wdata_out = ~d;
			ak = ack_in;
			rd = rdata_in;
			sk = skip_in;
			rf = refused_in;
		end
	endtask
endmodule // iorsd_core_model

// ==== iorsd_decoder_bench.sv ====
`timescale 1ns/1ps

module iorsd_decoder_bench;
	reg sys_clk_in = 1'b0;
	reg reset_in = 1'b1;
	reg [7:0] pin_b_in = 8'h3C;
	reg [7:0] pin_c_in = 8'h00;
	reg [7:0] pin_d_in = 8'h00;
	reg [47:0] flag_set_in = 48'h0;
	reg cmp_level_in = 1'b0;
	reg [1:0] spi_status_in = 2'h0;
	reg [3:0] reset_cause_in = 4'h0;
	// bench's own copy of the port b drive value
	reg [7:0] pb_model = 8'h00;
	wire v, ack_out, skip_out, refused_out, per_wr_out;
	wire [2:0] k, b;
	wire [7:0] a, d, rdata_out, pbd, pbo, pcd, pco, pdd, pdo, per_wdata_out;
	wire [47:0] flags_out;
	wire [3:0] rco;
	wire [5:0] per_addr_out;
	integer err_total = 0;
	integer n_checks = 0;
	integer cyc = 0;
	integer i;

	iorsd_decoder u_dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .req_valid_in(v),
		.req_kind_in(k), .req_addr_in(a), .req_bit_in(b), .req_wdata_in(d),
		.ack_out(ack_out), .rdata_out(rdata_out), .skip_out(skip_out),
		.refused_out(refused_out), .pin_b_in(pin_b_in), .pin_c_in(pin_c_in),
		.pin_d_in(pin_d_in), .port_b_dir_out(pbd), .port_b_drive_out(pbo),
		.port_c_dir_out(pcd), .port_c_drive_out(pco), .port_d_dir_out(pdd),
		.port_d_drive_out(pdo), .flag_set_in(flag_set_in), .cmp_level_in(cmp_level_in),
		.spi_status_in(spi_status_in), .reset_cause_in(reset_cause_in),
		.flags_out(flags_out), .reset_cause_out(rco), .per_wr_out(per_wr_out),
		.per_addr_out(per_addr_out), .per_wdata_out(per_wdata_out));

	iorsd_core_model u_core (.sys_clk_in(sys_clk_in), .req_valid_out(v), .req_kind_out(k),
		.req_addr_out(a), .req_bit_out(b), .req_wdata_out(d), .ack_in(ack_out),
		.rdata_in(rdata_out), .skip_in(skip_out), .refused_in(refused_out));

	always #10 sys_clk_in = ~sys_clk_in;

	task final_report;
		begin
			$display("checks=%0d errors=%0d", n_checks, err_total);
			if (err_total == 0 && n_checks > 0) begin
				$display("ALL TESTS PASSED");
			end else begin
				$display("TESTS FAILED");
			end
			$finish;
		end
	endtask

	// far above the roughly 110 cycles the tests need
	always @(posedge sys_clk_in) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			err_total = err_total + 1;
			final_report;
		end
	end

	task chk(input [7:0] g, input [7:0] e);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				err_total = err_total + 1;
				$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
			end
		end
	endtask

	task op(input [2:0] ok, input [7:0] oa, input [2:0] ob, input [7:0] od,
		input [7:0] er, input ef);
		reg ak, sk, rf;
		reg [7:0] rd;
		begin
			u_core.acc(ok, oa, ob, od, ak, rd, sk, rf);
			chk({7'h00, ak}, 8'h01);
			chk(rd, er);
			chk({7'h00, rf}, {7'h00, ef});
			chk({7'h00, sk}, {7'h00, ok[2] & ~ok[1] & ~ef & ~(ok[0] ^ ~pb_model[ob])});
		end
	endtask

	initial begin
		repeat (8) @(posedge sys_clk_in);
		#1;
		reset_in = 1'b0;
		op(3'h1, 8'h05, 3'h0, 8'h5A, 8'h00, 1'b0);
		op(3'h7, 8'h25, 3'h0, 8'hA5, 8'h00, 1'b0);
		chk({2'b00, per_addr_out}, 8'h05);
		chk(pbo, 8'hA5);
		chk(per_wdata_out, 8'hA5);
		op(3'h0, 8'h05, 3'h0, 8'h00, 8'hA5, 1'b0);
		op(3'h7, 8'h28, 3'h0, 8'hFF, 8'h00, 1'b0);
		chk(pco, 8'h7F);
		op(3'h1, 8'h04, 3'h0, 8'h81, 8'h00, 1'b0);
		chk(pbd, 8'h81);
		op(3'h7, 8'h2A, 3'h0, 8'h3C, 8'h00, 1'b0);
		chk(pdd, 8'h3C);
		op(3'h1, 8'h0B, 3'h0, 8'hC3, 8'h00, 1'b0);
		chk(pdo, 8'hC3);
		op(3'h2, 8'h07, 3'h7, 8'h00, 8'h00, 1'b0);
		chk(pcd, 8'h00);
		op(3'h6, 8'h28, 3'h0, 8'h00, 8'h7F, 1'b0);
		op(3'h6, 8'h23, 3'h0, 8'h00, 8'h3C, 1'b0);
		op(3'h0, 8'h03, 3'h0, 8'h00, 8'h3C, 1'b0);
		$display("test map done");
		op(3'h3, 8'h05, 3'h0, 8'h00, 8'h00, 1'b0);
		chk(pbo, 8'hA4);
		op(3'h2, 8'h05, 3'h6, 8'h00, 8'h00, 1'b0);
		chk(pbo, 8'hE4);
		pb_model = 8'hE4;
		// skip tests hand back the tested register as read data
		for (i = 0; i < 8; i = i + 1) begin
			op(3'h4, 8'h05, i[2:0], 8'h00, pb_model, 1'b0);
			op(3'h5, 8'h05, i[2:0], 8'h00, pb_model, 1'b0);
		end
		op(3'h2, 8'h2C, 3'h0, 8'h00, 8'h00, 1'b1);
		op(3'h4, 8'h20, 3'h0, 8'h00, 8'h00, 1'b1);
		$display("test bits done");
		@(posedge sys_clk_in);
		#1;
		flag_set_in = 48'h07;
		@(posedge sys_clk_in);
		#1;
		flag_set_in = 48'h0;
		@(posedge sys_clk_in);
		#1;
		chk(flags_out[7:0], 8'h07);
		op(3'h1, 8'h15, 3'h0, 8'h00, 8'h00, 1'b0);
		chk(flags_out[7:0], 8'h07);
		op(3'h2, 8'h15, 3'h1, 8'h00, 8'h00, 1'b0);
		chk(flags_out[7:0], 8'h05);
		op(3'h3, 8'h15, 3'h2, 8'h00, 8'h00, 1'b0);
		op(3'h1, 8'h15, 3'h0, 8'h01, 8'h00, 1'b0);
		op(3'h0, 8'h15, 3'h0, 8'h00, 8'h04, 1'b0);
		$display("test flags done");
		cmp_level_in = 1'b1;
		spi_status_in = 2'h3;
		@(posedge sys_clk_in);
		#1;
		reset_cause_in = 4'h5;
		flag_set_in = 48'h1000_0000_0000;
		@(posedge sys_clk_in);
		#1;
		reset_cause_in = 4'h0;
		flag_set_in = 48'h0;
		chk({4'h0, rco}, 8'h05);
		op(3'h0, 8'h34, 3'h0, 8'h00, 8'h05, 1'b0);
		op(3'h0, 8'h30, 3'h0, 8'h00, 8'h30, 1'b0);
		op(3'h1, 8'h30, 3'h0, 8'h10, 8'h00, 1'b0);
		op(3'h6, 8'h50, 3'h0, 8'h00, 8'h20, 1'b0);
		op(3'h6, 8'h4D, 3'h0, 8'h00, 8'hC0, 1'b0);
		op(3'h1, 8'h34, 3'h0, 8'h01, 8'h00, 1'b0);
		chk({4'h0, rco}, 8'h01);
		$display("test status done");
		op(3'h0, 8'h40, 3'h0, 8'h00, 8'h00, 1'b1);
		op(3'h1, 8'h45, 3'h0, 8'h00, 8'h00, 1'b1);
		op(3'h6, 8'h10, 3'h0, 8'h00, 8'h00, 1'b1);
		op(3'h7, 8'h60, 3'h0, 8'h5A, 8'h00, 1'b0);
		chk({7'h00, per_wr_out}, 8'h00);
		op(3'h6, 8'h60, 3'h0, 8'h00, 8'h00, 1'b0);
		op(3'h1, 8'h01, 3'h0, 8'hAA, 8'h00, 1'b0);
		chk({7'h00, per_wr_out}, 8'h00);
		op(3'h0, 8'h01, 3'h0, 8'h00, 8'h00, 1'b0);
		$display("test ranges done");
		final_report;
	end
endmodule // iorsd_decoder_bench
